/* File: src/ssr_event_reg.sv */
`timescale 1ns/100ps
`default_nettype none
module ssr_event_reg #(
    parameter int         W     = 8,
    parameter logic [W-1:0] VALID = '1
) (
    input  wire logic         clk_sys,
    input  wire logic         rst_b,
    input  wire logic [W-1:0] events,
    ssr_evreg_if.evreg        bus
);
    // refuse widths that the answer word or the bit index cannot cover
    if (W < 1 || W > ssr_pkg::RSP_W || W > (1 << ssr_pkg::BIT_W)) begin : g_bad_w
        $error("ssr_event_reg: bad width");
    end
    logic [W-1:0] status_ff;
    logic [W-1:0] enable_ff;
    logic         summary_ff;
    // one-hot lane for single-bit accesses; out of range gives zero
    wire [W-1:0] sel_mask = {{(W-1){1'b0}}, 1'b1} << bus.bit_sel;
    wire         any_clr  = bus.clr_all | bus.rd_all | bus.rd_one;
    wire [W-1:0] clr_mask = (bus.clr_all | bus.rd_all) ? '1 :
                            (bus.rd_one ? sel_mask : '0);
    // events OR in after the clear so a same-cycle event survives
    wire [W-1:0] nxt_status = ((status_ff & ~clr_mask) | events) & VALID;
    wire [W-1:0] nxt_enable = bus.en_wr_all ? bus.en_data :
                              (!bus.en_wr_one ? enable_ff :
                              (bus.bit_val ? (enable_ff | sel_mask)
                                           : (enable_ff & ~sel_mask)));
    wire [W-1:0] masked     = status_ff & enable_ff;
    // summary lags its sources by one clock
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            status_ff  <= '0;
            enable_ff  <= '0;
            summary_ff <= 1'b0;
        end else begin
            status_ff  <= nxt_status;
            enable_ff  <= nxt_enable;
            summary_ff <= |masked;
        end
    end
    assign bus.status  = status_ff;
    assign bus.enable  = enable_ff;
    assign bus.summary = summary_ff;
    property p_evreg_sticky;
        @(posedge clk_sys) disable iff (!rst_b)
        !any_clr |=> ((status_ff & $past(status_ff)) == $past(status_ff));
    endproperty
    a_evreg_sticky: assert property (p_evreg_sticky) else $error("status bit lost");
    property p_evreg_summary;
        @(posedge clk_sys) disable iff (!rst_b)
        (masked != '0) |=> summary_ff;
    endproperty
    a_evreg_summary: assert property (p_evreg_summary) else $error("summary missed");
    property p_evreg_release;
        @(posedge clk_sys) disable iff (!rst_b)
        (masked == '0) |=> !summary_ff;
    endproperty
    a_evreg_release: assert property (p_evreg_release) else $error("summary stuck");
endmodule
`default_nettype wire

/* File: src/ssr_evreg_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface ssr_evreg_if #(parameter int W = 8);
    logic                  clr_all;
    logic                  rd_all;
    logic                  rd_one;
    logic                  en_wr_all;
    logic                  en_wr_one;
    logic [ssr_pkg::BIT_W-1:0] bit_sel;
    logic [W-1:0]          en_data;
    logic                  bit_val;
    logic [W-1:0]          status;
    logic [W-1:0]          enable;
    logic                  summary;
    modport ctrl (output clr_all, rd_all, rd_one, en_wr_all, en_wr_one, bit_sel,
                  en_data, bit_val, input status, enable, summary);
    modport evreg (input clr_all, rd_all, rd_one, en_wr_all, en_wr_one, bit_sel,
                   en_data, bit_val, output status, enable, summary);
endinterface
`default_nettype wire

/* File: src/ssr_pkg.sv */
// Notes on behaviour
// - status bit reads 1 when event/condition present
// - summary bits 2,3,5 summarise fault,lockin,standard
// - summary bit 4 high while output buffer nonempty
// - summary bit 6 shows service request occurred
// - summary bit set when enabled source bit set
// - summary bit stays until enabled bits clear
// - querying summary byte never clears it
// - queried bit 6 is OR of enabled summary bits
// - serial poll changes only bit 6
// - first poll returns request, then withdraws it
// - request raised only on enabled rising bit
// - steady summary bit gives exactly one request
// - several source bits together give one request
// - standard bits 0,1,3; overflows flush queues
// - standard bits 4,5,6,7: exec, illegal, panel, power
// - standard, lockin, fault bits are sticky
// - lockin bits 0,1,3,4 overloads and unlock
// - lockin bits 5,6,7 sync filter and storage trigger
// - lockin bits 8-11 data overloads, 12-14 capture/sweep
// - fault bits 0,1 reference clock and battery
// - fault bits 4-7 network, transfer, usb faults
// - whole read clears all, bit read clears one
// - clear-all zeroes status, keeps enables
// - enables written whole or by bit, read both ways
`default_nettype none
package ssr_pkg;
    localparam int RSP_W   = 16;
    localparam int BIT_W   = 4;
    localparam int SPB_W   = 8;
    localparam int STD_W   = 8;
    localparam int LIA_W   = 15;
    localparam int FLT_W   = 8;
    // summary byte positions
    localparam int SPB_FLT = 2;
    localparam int SPB_LIA = 3;
    localparam int SPB_MAV = 4;
    localparam int SPB_STD = 5;
    localparam int SPB_RQS = 6;
    // summary bits that may raise a request (6 never does)
    localparam logic [SPB_W-1:0] SPB_SRC_MASK = 8'h3C;
    // standard event positions
    localparam int STD_OPC  = 0;
    localparam int STD_INQ  = 1;
    localparam int STD_OUTQ = 3;
    localparam int STD_EXEC = 4;
    localparam int STD_CMD  = 5;
    localparam int STD_USER = 6;
    localparam int STD_BOOT = 7;
    // implemented bits, unused status positions read zero
    localparam logic [STD_W-1:0] STD_VALID = 8'hFB;
    localparam logic [LIA_W-1:0] LIA_VALID = 15'h7FFB;
    localparam logic [FLT_W-1:0] FLT_VALID = 8'hF3;
    localparam logic [SPB_W-1:0] SPB_RST   = 8'h00;
    typedef enum logic [2:0] {
        SSR_OP_RD_STAT, SSR_OP_RD_STAT_BIT, SSR_OP_WR_EN, SSR_OP_WR_EN_BIT,
        SSR_OP_RD_EN, SSR_OP_RD_EN_BIT, SSR_OP_CLEAR_ALL, SSR_OP_NOP
    } ssr_op_e;
    typedef enum logic [1:0] {
        SSR_SEL_SUMMARY, SSR_SEL_STD, SSR_SEL_LOCKIN, SSR_SEL_FAULT
    } ssr_sel_e;
endpackage
`default_nettype wire

/* File: src/ssr_status_top.sv */
`timescale 1ns/100ps
`default_nettype none
module ssr_status_top (
    input  wire logic                          clk_sys,
    input  wire logic                          rst_b,
    // query and enable command port
    input  wire logic                          cmd_valid,
    input  wire ssr_pkg::ssr_op_e              cmd_op,
    input  wire ssr_pkg::ssr_sel_e             cmd_sel,
    input  wire logic [ssr_pkg::BIT_W-1:0]     cmd_bit,
    input  wire logic [ssr_pkg::RSP_W-1:0]     cmd_data,
    output logic                               rsp_valid,
    output logic [ssr_pkg::RSP_W-1:0]          rsp_data,
    // standard event sources, one-cycle pulses
    input  wire logic                          ev_op_complete,
    input  wire logic                          input_queue_overflow,
    input  wire logic                          output_queue_overflow,
    input  wire logic                          execution_error,
    input  wire logic                          ev_illegal_command,
    input  wire logic                          user_panel_action,
    // lockin and fault sources, by bit position
    input  wire logic [ssr_pkg::LIA_W-1:0]     lockin_events,
    input  wire logic [ssr_pkg::FLT_W-1:0]     fault_events,
    // interface side
    input  wire logic                          out_buf_nonempty,
    input  wire logic                          serial_poll,
    output logic                               poll_valid,
    output logic [ssr_pkg::SPB_W-1:0]          poll_byte,
    output logic                               srq_req,
    output logic                               queue_flush
);
    ssr_evreg_if #(.W(ssr_pkg::STD_W)) if_std ();
    ssr_evreg_if #(.W(ssr_pkg::LIA_W)) if_lia ();
    ssr_evreg_if #(.W(ssr_pkg::FLT_W)) if_flt ();

    logic                      power_on_flag_ff;
    logic                      mav_ff;
    logic [ssr_pkg::SPB_W-1:0] srq_en_ff;
    logic [ssr_pkg::SPB_W-1:0] prev_enabled_ff;
    logic                      srq_pend_ff;
    logic                      poll_valid_ff;
    logic [ssr_pkg::SPB_W-1:0] poll_byte_ff;
    logic                      rsp_valid_ff;
    logic [ssr_pkg::RSP_W-1:0] rsp_data_ff;
    logic                      queue_flush_ff;
    logic [ssr_pkg::STD_W-1:0] std_events;

    // command decode
    wire op_rd_stat     = cmd_valid && (cmd_op == ssr_pkg::SSR_OP_RD_STAT);
    wire op_rd_stat_bit = cmd_valid && (cmd_op == ssr_pkg::SSR_OP_RD_STAT_BIT);
    wire op_wr_en       = cmd_valid && (cmd_op == ssr_pkg::SSR_OP_WR_EN);
    wire op_wr_en_bit   = cmd_valid && (cmd_op == ssr_pkg::SSR_OP_WR_EN_BIT);
    wire op_rd_en       = cmd_valid && (cmd_op == ssr_pkg::SSR_OP_RD_EN);
    wire op_rd_en_bit   = cmd_valid && (cmd_op == ssr_pkg::SSR_OP_RD_EN_BIT);
    wire op_clear_all   = cmd_valid && (cmd_op == ssr_pkg::SSR_OP_CLEAR_ALL);
    wire any_read       = op_rd_stat | op_rd_stat_bit | op_rd_en | op_rd_en_bit;
    wire is_bit_read    = op_rd_stat_bit | op_rd_en_bit;
    wire is_en_read     = op_rd_en | op_rd_en_bit;

    wire sel_sum = (cmd_sel == ssr_pkg::SSR_SEL_SUMMARY);
    wire sel_std = (cmd_sel == ssr_pkg::SSR_SEL_STD);
    wire sel_lia = (cmd_sel == ssr_pkg::SSR_SEL_LOCKIN);
    wire sel_flt = (cmd_sel == ssr_pkg::SSR_SEL_FAULT);

    // standard event register controls
    assign if_std.clr_all   = op_clear_all;
    assign if_std.rd_all    = op_rd_stat && sel_std;
    assign if_std.rd_one    = op_rd_stat_bit && sel_std;
    assign if_std.en_wr_all = op_wr_en && sel_std;
    assign if_std.en_wr_one = op_wr_en_bit && sel_std;
    assign if_std.bit_sel   = cmd_bit;
    assign if_std.en_data   = cmd_data[ssr_pkg::STD_W-1:0];
    assign if_std.bit_val   = cmd_data[0];

    // lockin condition register controls
    assign if_lia.clr_all   = op_clear_all;
    assign if_lia.rd_all    = op_rd_stat && sel_lia;
    assign if_lia.rd_one    = op_rd_stat_bit && sel_lia;
    assign if_lia.en_wr_all = op_wr_en && sel_lia;
    assign if_lia.en_wr_one = op_wr_en_bit && sel_lia;
    assign if_lia.bit_sel   = cmd_bit;
    assign if_lia.en_data   = cmd_data[ssr_pkg::LIA_W-1:0];
    assign if_lia.bit_val   = cmd_data[0];

    // fault register controls
    assign if_flt.clr_all   = op_clear_all;
    assign if_flt.rd_all    = op_rd_stat && sel_flt;
    assign if_flt.rd_one    = op_rd_stat_bit && sel_flt;
    assign if_flt.en_wr_all = op_wr_en && sel_flt;
    assign if_flt.en_wr_one = op_wr_en_bit && sel_flt;
    assign if_flt.bit_sel   = cmd_bit;
    assign if_flt.en_data   = cmd_data[ssr_pkg::FLT_W-1:0];
    assign if_flt.bit_val   = cmd_data[0];

    // standard event vector; bit 2 left idle
    always_comb begin
        std_events                    = '0;
        std_events[ssr_pkg::STD_OPC]  = ev_op_complete;
        std_events[ssr_pkg::STD_INQ]  = input_queue_overflow;
        std_events[ssr_pkg::STD_OUTQ] = output_queue_overflow;
        std_events[ssr_pkg::STD_EXEC] = execution_error;
        std_events[ssr_pkg::STD_CMD]  = ev_illegal_command;
        std_events[ssr_pkg::STD_USER] = user_panel_action;
        std_events[ssr_pkg::STD_BOOT] = power_on_flag_ff;
    end

    ssr_event_reg #(.W(ssr_pkg::STD_W), .VALID(ssr_pkg::STD_VALID)) u_std (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .events  (std_events),
        .bus     (if_std)
    );
    // unused positions masked off inside the register
    ssr_event_reg #(.W(ssr_pkg::LIA_W), .VALID(ssr_pkg::LIA_VALID)) u_lia (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .events  (lockin_events),
        .bus     (if_lia)
    );
    ssr_event_reg #(.W(ssr_pkg::FLT_W), .VALID(ssr_pkg::FLT_VALID)) u_flt (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .events  (fault_events),
        .bus     (if_flt)
    );

    // summary byte without bit 6; all inputs are already registered
    logic [ssr_pkg::SPB_W-1:0] spb_base;
    always_comb begin
        spb_base                   = ssr_pkg::SPB_RST;
        spb_base[ssr_pkg::SPB_FLT] = if_flt.summary;
        spb_base[ssr_pkg::SPB_LIA] = if_lia.summary;
        spb_base[ssr_pkg::SPB_MAV] = mav_ff;
        spb_base[ssr_pkg::SPB_STD] = if_std.summary;
    end

    // enabled summary bits and their rising edges
    wire [ssr_pkg::SPB_W-1:0] enabled_vec = spb_base & srq_en_ff & ssr_pkg::SPB_SRC_MASK;
    wire [ssr_pkg::SPB_W-1:0] rise_vec    = enabled_vec & ~prev_enabled_ff;
    wire                      any_rise    = |rise_vec;
    wire                      rqs_query   = |enabled_vec;

    // query view: bit 6 is the level, not the pending request
    logic [ssr_pkg::SPB_W-1:0] spb_query;
    always_comb begin
        spb_query                   = spb_base;
        spb_query[ssr_pkg::SPB_RQS] = rqs_query;
    end

    // poll view: bit 6 is the pending request
    logic [ssr_pkg::SPB_W-1:0] spb_poll;
    always_comb begin
        spb_poll                   = spb_base;
        spb_poll[ssr_pkg::SPB_RQS] = srq_pend_ff;
    end

    // request latch: a rise in the poll cycle still wins
    wire nxt_srq_pend = any_rise | (srq_pend_ff & ~serial_poll);

    // serial-poll enable register update
    logic [ssr_pkg::SPB_W-1:0] bit_onehot;
    logic [ssr_pkg::SPB_W-1:0] nxt_srq_en;
    always_comb begin
        bit_onehot = {{(ssr_pkg::SPB_W-1){1'b0}}, 1'b1} << cmd_bit;
        nxt_srq_en = srq_en_ff;
        if (op_wr_en && sel_sum) begin
            nxt_srq_en = cmd_data[ssr_pkg::SPB_W-1:0];
        end else if (op_wr_en_bit && sel_sum) begin
            nxt_srq_en = cmd_data[0] ? (srq_en_ff | bit_onehot) : (srq_en_ff & ~bit_onehot);
        end
    end

    // read data selection, whole value before any clear
    logic [ssr_pkg::RSP_W-1:0] stat_word;
    logic [ssr_pkg::RSP_W-1:0] en_word;
    always_comb begin
        case (cmd_sel)
            ssr_pkg::SSR_SEL_SUMMARY: begin
                stat_word = ssr_pkg::RSP_W'(spb_query);
                en_word   = ssr_pkg::RSP_W'(srq_en_ff);
            end
            ssr_pkg::SSR_SEL_STD: begin
                stat_word = ssr_pkg::RSP_W'(if_std.status);
                en_word   = ssr_pkg::RSP_W'(if_std.enable);
            end
            ssr_pkg::SSR_SEL_LOCKIN: begin
                stat_word = ssr_pkg::RSP_W'(if_lia.status);
                en_word   = ssr_pkg::RSP_W'(if_lia.enable);
            end
            ssr_pkg::SSR_SEL_FAULT: begin
                stat_word = ssr_pkg::RSP_W'(if_flt.status);
                en_word   = ssr_pkg::RSP_W'(if_flt.enable);
            end
            default: begin
                stat_word = '0;
                en_word   = '0;
            end
        endcase
    end
    wire [ssr_pkg::RSP_W-1:0] word_sel  = is_en_read ? en_word : stat_word;
    // shift keeps an out-of-range bit index reading zero
    wire [ssr_pkg::RSP_W-1:0] bit_shift = word_sel >> cmd_bit;
    wire [ssr_pkg::RSP_W-1:0] nxt_rsp   = is_bit_read ?
                                          {{(ssr_pkg::RSP_W-1){1'b0}}, bit_shift[0]} : word_sel;

    // power-on flag fires once, in the first cycle after reset
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            power_on_flag_ff <= 1'b1;
            queue_flush_ff   <= 1'b0;
        end else begin
            power_on_flag_ff <= 1'b0;
            queue_flush_ff   <= input_queue_overflow | output_queue_overflow;
        end
    end

    // summary byte state and request latch
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            mav_ff          <= 1'b0;
            srq_en_ff       <= ssr_pkg::SPB_RST;
            prev_enabled_ff <= ssr_pkg::SPB_RST;
            srq_pend_ff     <= 1'b0;
        end else begin
            mav_ff          <= out_buf_nonempty;
            srq_en_ff       <= nxt_srq_en;
            prev_enabled_ff <= enabled_vec;
            srq_pend_ff     <= nxt_srq_pend;
        end
    end

    // answers: poll byte and query response
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            poll_valid_ff <= 1'b0;
            poll_byte_ff  <= ssr_pkg::SPB_RST;
            rsp_valid_ff  <= 1'b0;
            rsp_data_ff   <= '0;
        end else begin
            poll_valid_ff <= serial_poll;
            if (serial_poll) begin
                poll_byte_ff <= spb_poll;
            end
            rsp_valid_ff <= any_read;
            if (any_read) begin
                rsp_data_ff <= nxt_rsp;
            end
        end
    end

    assign poll_valid  = poll_valid_ff;
    assign poll_byte   = poll_byte_ff;
    assign rsp_valid   = rsp_valid_ff;
    assign rsp_data    = rsp_data_ff;
    assign srq_req     = srq_pend_ff;
    assign queue_flush = queue_flush_ff;

    // request latch: set by a rise, cleared by a poll
    property p_rise_sets;
        @(posedge clk_sys) disable iff (!rst_b)
        any_rise |=> srq_pend_ff;
    endproperty
    a_rise_sets: assert property (p_rise_sets) else $error("rise gave no request");

    property p_no_level_req;
        @(posedge clk_sys) disable iff (!rst_b)
        (!srq_pend_ff && !any_rise) |=> !srq_pend_ff;
    endproperty
    a_no_level_req: assert property (p_no_level_req) else $error("request without rise");

    property p_poll_withdraws;
        @(posedge clk_sys) disable iff (!rst_b)
        (serial_poll && srq_pend_ff && !any_rise)
            |=> poll_valid && poll_byte_ff[ssr_pkg::SPB_RQS]
            && !srq_pend_ff;
    endproperty
    a_poll_withdraws: assert property (p_poll_withdraws) else $error("poll kept request");

    property p_poll_keeps;
        @(posedge clk_sys) disable iff (!rst_b)
        serial_poll |=> (poll_byte_ff & ~(ssr_pkg::SPB_W'(1) << ssr_pkg::SPB_RQS))
                        == ($past(spb_base) & ~(ssr_pkg::SPB_W'(1) << ssr_pkg::SPB_RQS));
    endproperty
    a_poll_keeps: assert property (p_poll_keeps) else $error("poll byte altered");

    property p_query_level;
        @(posedge clk_sys) disable iff (!rst_b)
        (op_rd_stat && sel_sum) |=> rsp_valid && (rsp_data[ssr_pkg::SPB_RQS] == $past(rqs_query));
    endproperty
    a_query_level: assert property (p_query_level) else $error("query bit6 wrong");

    property p_mav;
        @(posedge clk_sys) disable iff (!rst_b)
        out_buf_nonempty |=> spb_base[ssr_pkg::SPB_MAV];
    endproperty
    a_mav: assert property (p_mav) else $error("buffer bit missing");

    property p_flush;
        @(posedge clk_sys) disable iff (!rst_b)
        (input_queue_overflow || output_queue_overflow) |=> queue_flush ##1 1'b1;
    endproperty
    a_flush: assert property (p_flush) else $error("no queue flush");

    property p_clear_keeps_en;
        @(posedge clk_sys) disable iff (!rst_b)
        op_clear_all |=> (srq_en_ff == $past(srq_en_ff))
                         && (if_lia.enable == $past(if_lia.enable));
    endproperty
    a_clear_keeps_en: assert property (p_clear_keeps_en) else $error("enables cleared");

    // standard summary follows its masked source
    property p_std_lag;
        @(posedge clk_sys) disable iff (!rst_b)
        spb_base[ssr_pkg::SPB_STD] == $past(|(if_std.status & if_std.enable));
    endproperty
    a_std_lag: assert property (p_std_lag) else $error("standard summary wrong");

    // lockin summary lags by one clock
    property p_lia_lag;
        @(posedge clk_sys) disable iff (!rst_b)
        spb_base[ssr_pkg::SPB_LIA] == $past(|(if_lia.status & if_lia.enable));
    endproperty
    a_lia_lag: assert property (p_lia_lag) else $error("lockin summary wrong");

    // fault summary at its own bit
    property p_flt_lag;
        @(posedge clk_sys) disable iff (!rst_b)
        spb_base[ssr_pkg::SPB_FLT] == $past(|(if_flt.status & if_flt.enable));
    endproperty
    a_flt_lag: assert property (p_flt_lag) else $error("fault summary wrong");

    // a pending request waits for a poll
    property p_pend_holds;
        @(posedge clk_sys) disable iff (!rst_b)
        (srq_pend_ff && !serial_poll) |=> srq_pend_ff;
    endproperty
    a_pend_holds: assert property (p_pend_holds) else $error("request dropped");

    // unchanged enabled bits never request
    property p_steady_no_req;
        @(posedge clk_sys) disable iff (!rst_b)
        (!srq_pend_ff && $stable(enabled_vec)) |=> !srq_pend_ff;
    endproperty
    a_steady_no_req: assert property (p_steady_no_req) else $error("level request");
endmodule
`default_nettype wire

/* File: test/ssr_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module ssr_host_model (
    input  wire logic       clk_sys,
    input  wire logic       rst_b,
    input  wire logic       srq_req,
    input  wire logic       poll_cmd,
    input  wire logic [3:0] delay,
    output logic            serial_poll
);
    logic       pend_ff;
    logic [3:0] cnt_ff;
    // answer each request by one serial poll after a chosen delay
    // serial_poll itself blocks a re-trigger while the request is still seen high
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            pend_ff     <= 1'b0;
            cnt_ff      <= 4'h0;
            serial_poll <= 1'b0;
        end else begin
            serial_poll <= 1'b0;
            if (poll_cmd) begin
                serial_poll <= 1'b1;
            end else if (pend_ff) begin
                if (cnt_ff == 4'h0) begin
                    serial_poll <= 1'b1;
                    pend_ff     <= 1'b0;
                end else begin
                    cnt_ff <= cnt_ff - 4'h1;
                end
            end else if (srq_req && !serial_poll) begin
                pend_ff <= 1'b1;
                cnt_ff  <= delay;
            end
        end
    end
endmodule
`default_nettype wire

/* File: test/tb_status_summary_service_request.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_status_summary_service_request;
    logic                      clk_sys = 1'b0, rst_b = 1'b0, cmd_valid = 1'b0;
    ssr_pkg::ssr_op_e          cmd_op  = ssr_pkg::SSR_OP_NOP;
    ssr_pkg::ssr_sel_e         cmd_sel = ssr_pkg::SSR_SEL_SUMMARY;
    logic [3:0]                cmd_bit = 4'h0, host_delay = 4'h0;
    logic [15:0]               cmd_data = 16'h0000, rsp_data, seed = 16'h0059, r;
    logic [5:0]                std_ev = 6'h00;
    logic [14:0]               lockin_events = 15'h0000;
    logic [7:0]                fault_events = 8'h00, poll_byte;
    logic                      out_buf_nonempty = 1'b0, poll_cmd = 1'b0;
    logic                      rsp_valid, poll_valid, srq_req, queue_flush, serial_poll;
    logic [15:0]               rsp_q[$];
    logic [7:0]                poll_q[$];
    int                        error_cnt = 0, compares = 0;
    ssr_status_top ssr_status_top_inst (.clk_sys(clk_sys), .rst_b(rst_b),
        .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_sel(cmd_sel), .cmd_bit(cmd_bit),
        .cmd_data(cmd_data), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
        .ev_op_complete(std_ev[0]), .input_queue_overflow(std_ev[1]),
        .output_queue_overflow(std_ev[2]), .execution_error(std_ev[3]),
        .ev_illegal_command(std_ev[4]), .user_panel_action(std_ev[5]),
        .lockin_events(lockin_events), .fault_events(fault_events),
        .out_buf_nonempty(out_buf_nonempty), .serial_poll(serial_poll),
        .poll_valid(poll_valid), .poll_byte(poll_byte), .srq_req(srq_req),
        .queue_flush(queue_flush));
    ssr_host_model ssr_host_model_inst (.clk_sys(clk_sys), .rst_b(rst_b), .srq_req(srq_req),
        .poll_cmd(poll_cmd), .delay(host_delay), .serial_poll(serial_poll));
    // 100 ns period
    initial begin
        forever #50 clk_sys = ~clk_sys;
    end
    function automatic logic [15:0] xs(input logic [15:0] s);
        s = s ^ (s << 7);
        s = s ^ (s >> 9);
        return s ^ (s << 8);
    endfunction
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        chk(16'(rsp_q.size() + poll_q.size()), 16'h0000);
        if (error_cnt == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    // reads leave a note for the watcher; writes and clear-all answer nothing
    task automatic cmd(input ssr_pkg::ssr_op_e op, input ssr_pkg::ssr_sel_e sel,
                       input logic [3:0] b, input logic [15:0] d, input logic [15:0] e);
        if (op inside {ssr_pkg::SSR_OP_RD_STAT, ssr_pkg::SSR_OP_RD_STAT_BIT,
                       ssr_pkg::SSR_OP_RD_EN, ssr_pkg::SSR_OP_RD_EN_BIT}) rsp_q.push_back(e);
        cmd_valid = 1'b1;
        cmd_op    = op;
        cmd_sel   = sel;
        cmd_bit   = b;
        cmd_data  = d;
        cyc(1);
        cmd_valid = 1'b0;
        cyc(1);
    endtask
    // one-cycle event pulse; flush must follow either overflow
    task automatic ev(input logic [14:0] lk, input logic [7:0] ft, input logic [5:0] sd);
        {lockin_events, fault_events, std_ev} = {lk, ft, sd};
        cyc(1);
        {lockin_events, fault_events, std_ev} = '0;
        @(negedge clk_sys);
        chk({15'h0000, queue_flush}, {15'h0000, sd[1] | sd[2]});
        cyc(1);
    endtask
    // watcher: settled outputs sampled on the falling edge
    always @(negedge clk_sys) begin
        if (rsp_valid === 1'b1) begin
            if (rsp_q.size() == 0) chk(rsp_data, 16'hFFFF);
            else chk(rsp_data, rsp_q.pop_front());
        end
        if (poll_valid === 1'b1) begin
            if (poll_q.size() == 0) chk({8'h00, poll_byte}, 16'hFFFF);
            else chk({8'h00, poll_byte}, {8'h00, poll_q.pop_front()});
        end
    end
    // watchdog at 4000 cycles, well beyond the roughly 120 cycles the sequence needs
    initial begin
        #400000;
        error_cnt++;
        end_of_test();
    end
    initial begin
        cyc(4);
        rst_b = 1'b1;
        cyc(3);
        cmd(ssr_pkg::SSR_OP_RD_STAT, ssr_pkg::SSR_SEL_STD, 0, 0, 16'h0080);
        cmd(ssr_pkg::SSR_OP_RD_STAT, ssr_pkg::SSR_SEL_STD, 0, 0, 16'h0000);
        ev(15'h0000, 8'h00, 6'h3F);
        cmd(ssr_pkg::SSR_OP_RD_STAT_BIT, ssr_pkg::SSR_SEL_STD, 3, 0, 16'h0001);
        cmd(ssr_pkg::SSR_OP_RD_STAT, ssr_pkg::SSR_SEL_STD, 0, 0, 16'h0073);
        cmd(ssr_pkg::SSR_OP_WR_EN, ssr_pkg::SSR_SEL_STD, 0, 16'h00FB, 0);
        cmd(ssr_pkg::SSR_OP_WR_EN_BIT, ssr_pkg::SSR_SEL_STD, 0, 16'h0000, 0);
        cmd(ssr_pkg::SSR_OP_RD_EN_BIT, ssr_pkg::SSR_SEL_STD, 0, 0, 16'h0000);
        cmd(ssr_pkg::SSR_OP_RD_EN, ssr_pkg::SSR_SEL_STD, 0, 0, 16'h00FA);
        cmd(ssr_pkg::SSR_OP_WR_EN_BIT, ssr_pkg::SSR_SEL_LOCKIN, 3, 16'h0001, 0);
        cmd(ssr_pkg::SSR_OP_WR_EN, ssr_pkg::SSR_SEL_SUMMARY, 0, 16'h0008, 0);
        // unlock raises one request, the host polls it away
        poll_q.push_back(8'h48);
        ev(15'h0008, 8'h00, 6'h00);
        cyc(12);
        cmd(ssr_pkg::SSR_OP_RD_STAT, ssr_pkg::SSR_SEL_SUMMARY, 0, 0, 16'h0048);
        cmd(ssr_pkg::SSR_OP_RD_STAT, ssr_pkg::SSR_SEL_SUMMARY, 0, 0, 16'h0048);
        poll_q.push_back(8'h08);
        poll_cmd = 1'b1;
        cyc(1);
        poll_cmd = 1'b0;
        cyc(4);
        ev(15'h0008, 8'h00, 6'h00);
        cyc(12);
        chk({15'h0000, srq_req}, 16'h0000);
        cmd(ssr_pkg::SSR_OP_RD_STAT_BIT, ssr_pkg::SSR_SEL_LOCKIN, 3, 0, 16'h0001);
        cyc(3);
        cmd(ssr_pkg::SSR_OP_RD_STAT, ssr_pkg::SSR_SEL_SUMMARY, 0, 0, 16'h0000);
        // many lockin bits at once, slow host: still a single request
        host_delay = 4'h5;
        cmd(ssr_pkg::SSR_OP_WR_EN, ssr_pkg::SSR_SEL_LOCKIN, 0, 16'h7FFF, 0);
        seed = xs(seed);
        r = seed | 16'h0008;
        poll_q.push_back(8'h48);
        ev(r[14:0], 8'h00, 6'h00);
        cyc(20);
        cmd(ssr_pkg::SSR_OP_RD_STAT, ssr_pkg::SSR_SEL_LOCKIN, 0, 0, r & 16'h7FFB);
        seed = xs(seed);
        ev(15'h0000, seed[7:0], 6'h00);
        cmd(ssr_pkg::SSR_OP_RD_STAT, ssr_pkg::SSR_SEL_FAULT, 0, 0, seed & 16'h00F3);
        ev(15'h0000, 8'hFF, 6'h00);
        cmd(ssr_pkg::SSR_OP_CLEAR_ALL, ssr_pkg::SSR_SEL_FAULT, 0, 0, 0);
        cmd(ssr_pkg::SSR_OP_RD_STAT, ssr_pkg::SSR_SEL_FAULT, 0, 0, 16'h0000);
        cmd(ssr_pkg::SSR_OP_RD_EN, ssr_pkg::SSR_SEL_SUMMARY, 0, 0, 16'h0008);
        out_buf_nonempty = 1'b1;
        cyc(3);
        cmd(ssr_pkg::SSR_OP_RD_STAT, ssr_pkg::SSR_SEL_SUMMARY, 0, 0, 16'h0010);
        cyc(3);
        end_of_test();
    end
endmodule
`default_nettype wire
